// >>> pkg/bcdalu_map.vh
/*
 Constants for the decimal-adjust and decrement ALU slice: opcodes, flag positions,
 correction bytes and cycle count. Assumes it is included once per compile unit.
*/
// What this block does
// - Decimal adjust rewrites the byte as two packed BCD digits after add or subtract.
// - After add, add 00/06/60/66 from carry, nibbles, half-carry; carry set when 60 included.
// - After subtract, add 00/FA/A0/9A; carry after equals carry before.
// - Decimal adjust sets carry from the correction table, clears it otherwise.
// - Decimal adjust sets zero when the corrected byte is zero.
// - Decimal adjust copies corrected bit 7 into the sign flag.
// - Decrement subtracts one from the byte and writes it back in place.
// - Indirect decrement uses the pointer register contents as address; pointer unchanged.
`ifndef BCDALU_MAP_VH
`define BCDALU_MAP_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define BCDALU_OPC_ADJUST_REG 8'h40
`define BCDALU_OPC_ADJUST_IND 8'h41
`define BCDALU_OPC_DECREMENT_REG 8'h00
`define BCDALU_OPC_DECREMENT_IND 8'h01
// ----------------------------------------
// Flag byte positions
// ----------------------------------------
`define BCDALU_FLG_C 7
`define BCDALU_FLG_Z 6
`define BCDALU_FLG_S 5
`define BCDALU_FLG_V 4
`define BCDALU_FLG_D 3
`define BCDALU_FLG_H 2
// ----------------------------------------
// Corrections and limits
// ----------------------------------------
`define BCDALU_COR_NONE 8'h00
`define BCDALU_COR_LO 8'h06
`define BCDALU_COR_HI 8'h60
`define BCDALU_COR_BOTH 8'h66
`define BCDALU_SCOR_LO 8'hFA
`define BCDALU_SCOR_HI 8'hA0
`define BCDALU_SCOR_BOTH 8'h9A
`define BCDALU_NIB_NINE 4'h9
`define BCDALU_ONE 8'h01
`define BCDALU_INSN_CYCLES 2'h3
`endif

// >>> design/bcdalu_core.v
/*
 Combinational decimal-adjust and decrement arithmetic with flag results.
 Assumes operands are stable from the sequencing logic on the same clock.
*/
`timescale 1ns/1ns
`include "bcdalu_map.vh"
module bcdalu_core (
    // Operands
    input wire [7:0] operand_in,
    input wire [7:0] flags_in,
    input wire sub_mode_in,
    input wire decrement_in,
    // Results
    output reg [7:0] result_out,
    output reg [7:0] flags_out
);
    reg [7:0] cor;
    reg carry;
    reg hi_fix;
    wire c0 = flags_in[`BCDALU_FLG_C];
    wire h0 = flags_in[`BCDALU_FLG_H];
    wire [3:0] hi = operand_in[7:4];
    wire [3:0] lo = operand_in[3:0];
    wire lo_bad = (lo > `BCDALU_NIB_NINE);
    always @* begin
        cor = `BCDALU_COR_NONE;
        carry = c0;
        hi_fix = 1'b0;
        // Compact form of the table; invalid inputs fall out arbitrarily
        if (sub_mode_in) begin
            if (h0 && c0) cor = `BCDALU_SCOR_BOTH;
            else if (c0) cor = `BCDALU_SCOR_HI;
            else if (h0) cor = `BCDALU_SCOR_LO;
            carry = c0;
        end else begin
            if (h0 || lo_bad) cor = `BCDALU_COR_LO;
            hi_fix = c0 || (hi > `BCDALU_NIB_NINE) || (hi == `BCDALU_NIB_NINE && lo_bad);
            // Upper correction is what carries out of bit 7
            if (hi_fix) cor = cor | `BCDALU_COR_HI;
            carry = hi_fix;
        end
        result_out = operand_in + cor;
        flags_out = flags_in;
        if (decrement_in) begin
            result_out = operand_in - `BCDALU_ONE;
            flags_out[`BCDALU_FLG_V] = (operand_in == 8'h80);
        end else begin
            flags_out[`BCDALU_FLG_C] = carry;
        end
        flags_out[`BCDALU_FLG_Z] = (result_out == 8'h00);
        flags_out[`BCDALU_FLG_S] = result_out[7];
    end
endmodule

// >>> design/bcdalu_top.v
/*
 Sequencer for decimal adjust and decrement: register and indirect forms over four cycles.
 Assumes a single-cycle register file read port and write port on the same clock.
*/
`timescale 1ns/1ns
`include "bcdalu_map.vh"
module bcdalu_top (
    // Clock and reset
    input wire REF_CLK_IN,
    input wire RST_N_IN,
    // Instruction
    input wire START_IN,
    input wire [7:0] OPCODE_IN,
    input wire [7:0] DST_IN,
    input wire SUB_MODE_IN,
    input wire [7:0] FLAGS_IN,
    // Register file
    input wire [7:0] RF_RDATA_IN,
    output reg [7:0] RF_RADDR_OUT,
    output reg RF_WE_OUT,
    output reg [7:0] RF_WADDR_OUT,
    output reg [7:0] RF_WDATA_OUT,
    // Status
    output reg [7:0] FLAGS_OUT,
    output reg FLAGS_WE_OUT,
    output wire BUSY_OUT,
    output reg DONE_OUT,
    output reg ILLEGAL_OUT
);
    // ----------------------------------------
    // State and storage
    // ----------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_PTR = 2'h1;
    localparam ST_OPND = 2'h2;
    localparam ST_WB = 2'h3;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [1:0] cyc;
    reg [1:0] next_cyc;
    reg decrement;
    reg sub_mode;
    reg [7:0] flags;
    reg [7:0] addr;
    reg [7:0] next_addr;
    reg [7:0] opnd;
    reg [7:0] next_opnd;
    reg [7:0] next_raddr;
    wire [7:0] alu_res;
    wire [7:0] alu_flags;
    wire legal;
    wire indirect;
    wire idle;
    wire take;
    wire refuse;
    wire last_wait;
    wire write_back;
    // ----------------------------------------
    // Opcode decode
    // ----------------------------------------
    function op_legal;
        input [7:0] op;
        begin
            op_legal = (op == `BCDALU_OPC_ADJUST_REG) || (op == `BCDALU_OPC_ADJUST_IND) ||
                (op == `BCDALU_OPC_DECREMENT_REG) || (op == `BCDALU_OPC_DECREMENT_IND);
        end
    endfunction
    // Full compares, so an unknown opcode never selects a form
    function op_indirect;
        input [7:0] op;
        begin
            op_indirect = (op == `BCDALU_OPC_ADJUST_IND) || (op == `BCDALU_OPC_DECREMENT_IND);
        end
    endfunction
    function op_decrement;
        input [7:0] op;
        begin
            op_decrement = (op == `BCDALU_OPC_DECREMENT_REG) || (op == `BCDALU_OPC_DECREMENT_IND);
        end
    endfunction
    assign legal = op_legal(OPCODE_IN);
    assign indirect = op_indirect(OPCODE_IN);
    assign idle = (state == ST_IDLE);
    // A start during a run is dropped silently rather than queued
    assign take = START_IN && idle && legal;
    assign refuse = START_IN && idle && !legal;
    // Pad the direct form so both forms take four cycles
    assign last_wait = (cyc == `BCDALU_INSN_CYCLES - 2'h1);
    assign write_back = (state == ST_WB);
    assign BUSY_OUT = !idle;
    // ----------------------------------------
    // Arithmetic
    // ----------------------------------------
    bcdalu_core u_core (
        .operand_in(opnd),
        .flags_in(flags),
        .sub_mode_in(sub_mode),
        .decrement_in(decrement),
        .result_out(alu_res),
        .flags_out(alu_flags)
    );
    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = indirect ? ST_PTR : ST_OPND;
                end
            end
            ST_PTR: begin
                next_state = ST_OPND;
            end
            ST_OPND: begin
                if (last_wait) begin
                    next_state = ST_WB;
                end
            end
            ST_WB: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end
    // Count restarts on every taken instruction
    always @* begin
        next_cyc = cyc + 2'h1;
        if (idle) begin
            next_cyc = 2'h0;
        end
    end
    // ----------------------------------------
    // Next values
    // ----------------------------------------
    always @* begin
        next_addr = addr;
        next_raddr = RF_RADDR_OUT;
        next_opnd = opnd;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_addr = DST_IN;
                    next_raddr = DST_IN;
                end
            end
            ST_PTR: begin
                // Pointer contents become the target; pointer is never written
                next_addr = RF_RDATA_IN;
                next_raddr = RF_RDATA_IN;
            end
            ST_OPND: begin
                // Read port has settled by the last pad cycle; the last capture wins
                next_opnd = RF_RDATA_IN;
            end
            default: begin
                next_opnd = opnd;
            end
        endcase
    end
    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state <= ST_IDLE;
            cyc <= 2'h0;
        end else begin
            state <= next_state;
            cyc <= next_cyc;
        end
    end
    // Operation and flags freeze at the start so inputs may move during a run
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            decrement <= 1'b0;
            sub_mode <= 1'b0;
            flags <= 8'h00;
        end else if (take) begin
            decrement <= op_decrement(OPCODE_IN);
            sub_mode <= SUB_MODE_IN;
            flags <= FLAGS_IN;
        end
    end
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            addr <= 8'h00;
            opnd <= 8'h00;
            RF_RADDR_OUT <= 8'h00;
        end else begin
            addr <= next_addr;
            opnd <= next_opnd;
            RF_RADDR_OUT <= next_raddr;
        end
    end
    // ----------------------------------------
    // Write-back
    // ----------------------------------------
    // Address, data and flags hold until the next write-back
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            RF_WADDR_OUT <= 8'h00;
            RF_WDATA_OUT <= 8'h00;
            FLAGS_OUT <= 8'h00;
        end else if (write_back) begin
            RF_WADDR_OUT <= addr;
            RF_WDATA_OUT <= alu_res;
            FLAGS_OUT <= alu_flags;
        end
    end
    // Write and done strobes are single-cycle pulses; ILLEGAL_OUT stays high while an illegal start is held
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            RF_WE_OUT <= 1'b0;
            FLAGS_WE_OUT <= 1'b0;
            DONE_OUT <= 1'b0;
            ILLEGAL_OUT <= 1'b0;
        end else begin
            RF_WE_OUT <= write_back;
            FLAGS_WE_OUT <= write_back;
            DONE_OUT <= write_back;
            ILLEGAL_OUT <= refuse;
        end
    end
endmodule

// >>> tb/bcdalu_properties.sv
/* Port checker for bcdalu_top.
 Assumes one clock and an async active-low reset. */
`timescale 1ns/1ns
module bcdalu_properties (
    input wire REF_CLK_IN, RST_N_IN, START_IN, SUB_MODE_IN, BUSY_OUT,
    input wire RF_WE_OUT, FLAGS_WE_OUT, DONE_OUT, ILLEGAL_OUT,
    input wire [7:0] OPCODE_IN, FLAGS_IN, RF_WDATA_OUT, FLAGS_OUT
);
    // Zero only for opcodes 00, 01, 40, 41
    wire legal = (OPCODE_IN & 8'hBE) == 8'h00;
    wire take = START_IN && !BUSY_OUT && legal;
    reg adj, sub;
    reg [7:0] fin;
    always @(posedge REF_CLK_IN or negedge RST_N_IN)
        if (!RST_N_IN) {adj, sub, fin} <= 10'h000;
        else if (take) {adj, sub, fin} <= {OPCODE_IN[6], SUB_MODE_IN, FLAGS_IN};
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // --------
    // Checks
    // --------
    // Strobes set at the fourth edge are sampled one edge later
    property p_lat; take |-> ##5 DONE_OUT && RF_WE_OUT && FLAGS_WE_OUT; endproperty
    a_lat: assert property (p_lat) else $error("late write");
    property p_busy; take |=> BUSY_OUT[*4] ##1 !BUSY_OUT; endproperty
    a_busy: assert property (p_busy) else $error("busy dropped");
    property p_ill; START_IN && !BUSY_OUT && !legal |=> ILLEGAL_OUT; endproperty
    a_ill: assert property (p_ill) else $error("no illegal pulse");
    property p_one; DONE_OUT |=> !DONE_OUT && !RF_WE_OUT; endproperty
    a_one: assert property (p_one) else $error("long strobe");
    property p_zero; FLAGS_WE_OUT |-> FLAGS_OUT[6] == (RF_WDATA_OUT == 8'h00); endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_sign; FLAGS_WE_OUT && adj |-> FLAGS_OUT[5] == RF_WDATA_OUT[7]; endproperty
    a_sign: assert property (p_sign) else $error("sign flag");
    property p_carry; FLAGS_WE_OUT && (!adj || sub) |-> FLAGS_OUT[7] == fin[7]; endproperty
    a_carry: assert property (p_carry) else $error("carry flag");
    property p_keep; FLAGS_WE_OUT |-> FLAGS_OUT[3:2] == fin[3:2]; endproperty
    a_keep: assert property (p_keep) else $error("kept flags");
    c_ind: cover property (take && OPCODE_IN[0]);
    c_sub: cover property (FLAGS_WE_OUT && adj && sub);
    c_ill: cover property (ILLEGAL_OUT);
    c_cry: cover property (FLAGS_WE_OUT && adj && !sub && FLAGS_OUT[7]);
endmodule
bind bcdalu_top bcdalu_properties u_prop (
    .REF_CLK_IN(REF_CLK_IN),
    .RST_N_IN(RST_N_IN),
    .START_IN(START_IN),
    .SUB_MODE_IN(SUB_MODE_IN),
    .BUSY_OUT(BUSY_OUT),
    .RF_WE_OUT(RF_WE_OUT),
    .FLAGS_WE_OUT(FLAGS_WE_OUT),
    .DONE_OUT(DONE_OUT),
    .ILLEGAL_OUT(ILLEGAL_OUT),
    .OPCODE_IN(OPCODE_IN),
    .FLAGS_IN(FLAGS_IN),
    .RF_WDATA_OUT(RF_WDATA_OUT),
    .FLAGS_OUT(FLAGS_OUT)
);

// >>> tb/bcdalu_top_tb_top.sv
/* Bench for bcdalu_top: random BCD adjust and decrement, both forms.
 Assumes the register file is this bench's array, read combinationally. */
`timescale 1ns/1ns
module bcdalu_top_tb_top;
    reg clk = 1'b0, rst_n = 1'b0, start = 1'b0, sub = 1'b0, cy;
    reg [7:0] opc = 8'h00, dst = 8'h00, fl = 8'h00, v, t, x, y;
    reg [7:0] rf [0:255];
    reg [31:0] e;
    reg [31:0] q [$];
    wire [7:0] raddr, waddr, wdata, flags;
    wire we, fwe, done, ill;
    integer num_errors = 0, check_count = 0, seed = 32'had36, i, r, a, b, c, k;
    bcdalu_top dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .START_IN(start), .OPCODE_IN(opc), .DST_IN(dst),
        .SUB_MODE_IN(sub), .FLAGS_IN(fl), .RF_RDATA_IN(rf[raddr]), .RF_RADDR_OUT(raddr), .RF_WE_OUT(we),
        .RF_WADDR_OUT(waddr), .RF_WDATA_OUT(wdata), .FLAGS_OUT(flags), .FLAGS_WE_OUT(fwe), .BUSY_OUT(),
        .DONE_OUT(done), .ILLEGAL_OUT(ill));
    initial forever #50 clk = ~clk;
    task check(input [7:0] seen, input [7:0] exp, input [39:0] what);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    // Note: write address, data, flags, flag mask (undefined flags masked)
    task issue(input [7:0] op, input [7:0] val, input [7:0] ev, input [7:0] ef, input [7:0] m);
        reg [7:0] p;
        begin
            p = dst ^ 8'h80;
            rf[dst] = op[0] ? p : val;
            rf[p] = op[0] ? val : ~val;
            q.push_back({op[0] ? p : dst, ev, ef, m});
            opc = op;
            start = 1'b1;
            @(negedge clk) opc = 8'h55;
            @(negedge clk) start = 1'b0;
            for (i = 0; i < 12 && done !== 1'b1; i = i + 1) @(negedge clk);
        end
    endtask
    // ----------
    // Watchers
    // ----------
    always @(negedge clk) if (done === 1'b1) begin
        check({7'h00, q.size() == 0}, 8'h00, "queue");
        e = q.size() > 0 ? q.pop_front() : 32'h0000_00FF;
        check({6'h00, we, fwe}, 8'h03, "strb");
        check(waddr, e[31:24], "waddr");
        check(wdata, e[23:16], "wdata");
        check(flags & e[7:0], e[15:8] & e[7:0], "flags");
    end
    initial begin
        #600000;
        num_errors = num_errors + 1;
        stop_test;
    end
    initial begin
        repeat (10) @(negedge clk);
        check({4'h0, we, fwe, done, ill}, 8'h00, "rst");
        rst_n = 1'b1;
        for (r = 0; r < 48; r = r + 1) begin
            a = {$random(seed)} % 100;
            b = {$random(seed)} % 100;
            c = {$random(seed)} % 2;
            x = a / 10 * 16 + a % 10;
            y = b / 10 * 16 + b % 10;
            fl = $random(seed);
            dst = $random(seed);
            sub = r % 3 == 1;
            if (sub) begin
                {fl[7], v} = {1'b0, x} - y - c;
                fl[2] = x[3:0] < y[3:0] + c;
            end else begin
                {fl[7], v} = {1'b0, x} + y + c;
                fl[2] = x[3:0] + y[3:0] + c > 15;
            end
            k = sub ? a - b - c : a + b + c;
            cy = sub ? k < 0 : k > 99;
            k = (k + 100) % 100;
            t = k / 10 * 16 + k % 10;
            if (r % 3 == 2) begin
                v = r == 2 ? 8'h01 : r == 5 ? 8'h00 : r == 8 ? 8'h80 : v;
                t = v - 8'h01;
                issue({7'h00, r[4]}, v, t, {fl[7], t == 8'h00, fl[5:0]}, 8'hCC);
            end else
                issue({7'h20, r[4]}, v, t, {cy, t == 8'h00, t[7], fl[4:0]}, 8'hEC);
        end
        opc = 8'h42;
        start = 1'b1;
        @(negedge clk) start = 1'b0;
        check({7'h00, ill}, 8'h01, "ill");
        repeat (8) @(negedge clk);
        check({7'h00, q.size() != 0}, 8'h00, "left");
        stop_test;
    end
endmodule
